//--- src/dpfm_pkg.sv
// Constants, field layout and carrier types for the dual pin function mux.
// Assumes one core clock domain; register access port is supplied by the
// device's own register interface (address, write strobe, data).
//
// Functional notes
// - Code 0 disables pin, buffers off
// - Code 1: pin feeds internal input mux
// - Code 3: pin drives own level bit
// - Code 4: pin drives shared bit-bang level
// - Code 5: pin drives PDM clock
// - Code 6: clock output; pin A PDM
// - Codes 7-10: interrupt lines, pin A variant
// - Code 12: primary frame clock out
// - Code 13: primary bit clock out
// - Codes 16-18,21,27-29: audio port outputs
// - Reset: selector 1, level 0, RW
package dpfm_pkg;

    // ========================================================================
    // Register map
    // ========================================================================
    localparam logic [7:0] DPFM_BIT_CLOCK_PIN_FUNCTION_OFS  = 8'h3D;
    localparam logic [7:0] DPFM_WORD_CLOCK_PIN_FUNCTION_OFS = 8'h3E;
    localparam logic [7:0] DPFM_PIN_FUNCTION_RESET          = 8'h01;

    // ========================================================================
    // Field layout
    // ========================================================================
    localparam int DPFM_SEL_LSB   = 0;
    localparam int DPFM_SEL_W     = 5;
    localparam int DPFM_LEVEL_BIT = 6;

    // ========================================================================
    // Selector codes
    // ========================================================================
    typedef enum logic [4:0] {
        DPFM_SEL_OFF        = 5'h00,
        DPFM_SEL_INPUT      = 5'h01,
        DPFM_SEL_LEVEL      = 5'h03,
        DPFM_SEL_BITBANG    = 5'h04,
        DPFM_SEL_PDM_CLK    = 5'h05,
        DPFM_SEL_CLK_OUT    = 5'h06,
        DPFM_SEL_IRQ1       = 5'h07,
        DPFM_SEL_IRQ2       = 5'h08,
        DPFM_SEL_IRQ3       = 5'h09,
        DPFM_SEL_IRQ4       = 5'h0A,
        DPFM_SEL_PRI_FRAME  = 5'h0C,
        DPFM_SEL_PRI_BIT    = 5'h0D,
        DPFM_SEL_PRI_DATA   = 5'h10,
        DPFM_SEL_PRI_FRAME2 = 5'h11,
        DPFM_SEL_SEC_BIT    = 5'h12,
        DPFM_SEL_SEC_DATA   = 5'h15,
        DPFM_SEL_MRG_FRAME  = 5'h1B,
        DPFM_SEL_MRG_BIT    = 5'h1C,
        DPFM_SEL_MRG_DATA   = 5'h1D
    } dpfm_sel_t;

    // ========================================================================
    // Internal signal sources that can be routed to a pin
    // ========================================================================
    typedef struct packed {
        logic shared_bitbang_level;
        logic pdm_clock;
        logic general_clock_output;
        logic irq_line_one;
        logic irq_line_two;
        logic irq_line_three;
        logic irq_line_four;
        logic primary_audio_frame_clock_out;
        logic primary_audio_bit_clock_out;
        logic primary_audio_data_out;
        logic secondary_audio_bit_clock_out;
        logic secondary_audio_data_out;
        logic merged_audio_frame_clock_out;
        logic merged_audio_bit_clock_out;
        logic merged_audio_data_out;
    } dpfm_src_t;

    // Pin drive state: output, output enable, input buffer enable
    typedef struct packed {
        logic out;
        logic oe;
        logic ie;
    } dpfm_drive_t;

endpackage : dpfm_pkg

//--- src/dpfm_pin_sel.sv
// One pin's function decoder: maps selector and level bits to a pin drive.
// Assumes source signals are synchronous to the core clock.
`timescale 1ns/1ps
module dpfm_pin_sel
    import dpfm_pkg::*;
#(
    parameter bit BIT_CLOCK_VARIANT = 1'b0
) (
    input  wire logic [7:0]  cfg_i,
    input  wire dpfm_src_t   src_i,
    output dpfm_drive_t      drive_o
);

    // ========================================================================
    // Decode
    // ========================================================================
    logic [DPFM_SEL_W-1:0] sel;
    logic                  lvl;
    assign sel = cfg_i[DPFM_SEL_LSB +: DPFM_SEL_W];
    assign lvl = cfg_i[DPFM_LEVEL_BIT];

    // Default off: reserved codes fall through here
    always_comb begin
        drive_o = '0;
        case (sel)
            DPFM_SEL_INPUT:      drive_o.ie = 1'b1;
            DPFM_SEL_LEVEL:      drive_o = '{out: lvl, oe: 1'b1, ie: 1'b0};
            DPFM_SEL_BITBANG:    drive_o = '{out: src_i.shared_bitbang_level,
                                             oe: 1'b1, ie: 1'b0};
            DPFM_SEL_PDM_CLK:    drive_o = '{out: src_i.pdm_clock, oe: 1'b1, ie: 1'b0};
            DPFM_SEL_CLK_OUT:    drive_o = '{out: BIT_CLOCK_VARIANT ? src_i.pdm_clock
                                             : src_i.general_clock_output,
                                             oe: 1'b1, ie: 1'b0};
            DPFM_SEL_IRQ1:       drive_o = '{out: src_i.irq_line_one, oe: 1'b1, ie: 1'b0};
            DPFM_SEL_IRQ2:       drive_o = '{out: src_i.irq_line_two, oe: 1'b1, ie: 1'b0};
            DPFM_SEL_IRQ3:       drive_o = '{out: BIT_CLOCK_VARIANT ? src_i.irq_line_two
                                             : src_i.irq_line_three,
                                             oe: 1'b1, ie: 1'b0};
            DPFM_SEL_IRQ4:       drive_o = '{out: BIT_CLOCK_VARIANT ? src_i.irq_line_three
                                             : src_i.irq_line_four,
                                             oe: 1'b1, ie: 1'b0};
            DPFM_SEL_PRI_FRAME,
            DPFM_SEL_PRI_FRAME2: drive_o = '{out: src_i.primary_audio_frame_clock_out,
                                             oe: 1'b1, ie: 1'b0};
            DPFM_SEL_PRI_BIT:    drive_o = '{out: src_i.primary_audio_bit_clock_out,
                                             oe: 1'b1, ie: 1'b0};
            DPFM_SEL_PRI_DATA:   drive_o = '{out: src_i.primary_audio_data_out,
                                             oe: 1'b1, ie: 1'b0};
            DPFM_SEL_SEC_BIT:    drive_o = '{out: src_i.secondary_audio_bit_clock_out,
                                             oe: 1'b1, ie: 1'b0};
            DPFM_SEL_SEC_DATA:   drive_o = '{out: src_i.secondary_audio_data_out,
                                             oe: 1'b1, ie: 1'b0};
            DPFM_SEL_MRG_FRAME:  drive_o = '{out: src_i.merged_audio_frame_clock_out,
                                             oe: 1'b1, ie: 1'b0};
            DPFM_SEL_MRG_BIT:    drive_o = '{out: src_i.merged_audio_bit_clock_out,
                                             oe: 1'b1, ie: 1'b0};
            DPFM_SEL_MRG_DATA:   drive_o = '{out: src_i.merged_audio_data_out,
                                             oe: 1'b1, ie: 1'b0};
            default:             drive_o = '0;
        endcase
    end

endmodule : dpfm_pin_sel

//--- src/dpfm_top.sv
// Dual pin function multiplexer: two 8-bit function registers and the pin
// drivers for the bit-clock-shared pin (pin A) and word-clock-shared pin (B).
// Assumes a simple synchronous register port from the device's control
// interface and that all sources are synchronous to core_clk_i.
`timescale 1ns/1ps
module dpfm_top
    import dpfm_pkg::*;
(
    input  wire logic        core_clk_i,
    input  wire logic        resetn_i,
    // Register port
    input  wire logic [7:0]  reg_addr_i,
    input  wire logic        reg_wr_i,
    input  wire logic [7:0]  reg_wdata_i,
    output logic      [7:0]  reg_rdata_o,
    // Internal sources
    input  wire dpfm_src_t   src_i,
    // Bit-clock-shared pin
    input  wire logic        bit_clock_shared_pin_i,
    output logic             bit_clock_shared_pin_o,
    output logic             bit_clock_shared_pin_oe_o,
    output logic             bit_clock_shared_pin_ie_o,
    output logic             pin_a_input_mux_o,
    // Word-clock-shared pin
    input  wire logic        word_clock_shared_pin_i,
    output logic             word_clock_shared_pin_o,
    output logic             word_clock_shared_pin_oe_o,
    output logic             word_clock_shared_pin_ie_o,
    output logic             pin_b_input_mux_o
);

    // ========================================================================
    // Function registers
    // ========================================================================
    logic [7:0] bit_clock_pin_function_r;
    logic [7:0] word_clock_pin_function_r;

    // All eight bits read/write, reset to input mode
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            bit_clock_pin_function_r  <= DPFM_PIN_FUNCTION_RESET;
            word_clock_pin_function_r <= DPFM_PIN_FUNCTION_RESET;
        end else if (reg_wr_i) begin
            if (reg_addr_i == DPFM_BIT_CLOCK_PIN_FUNCTION_OFS) begin
                bit_clock_pin_function_r <= reg_wdata_i;
            end else if (reg_addr_i == DPFM_WORD_CLOCK_PIN_FUNCTION_OFS) begin
                word_clock_pin_function_r <= reg_wdata_i;
            end
        end
    end

    // ========================================================================
    // Read data, registered; unmapped offsets read zero
    // ========================================================================
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            reg_rdata_o <= 8'h00;
        end else if (reg_addr_i == DPFM_BIT_CLOCK_PIN_FUNCTION_OFS) begin
            reg_rdata_o <= bit_clock_pin_function_r;
        end else if (reg_addr_i == DPFM_WORD_CLOCK_PIN_FUNCTION_OFS) begin
            reg_rdata_o <= word_clock_pin_function_r;
        end else begin
            reg_rdata_o <= 8'h00;
        end
    end

    // ========================================================================
    // Per-pin decode
    // ========================================================================
    dpfm_drive_t drive_a;
    dpfm_drive_t drive_b;

    dpfm_pin_sel #(.BIT_CLOCK_VARIANT(1'b1)) u_pin_a (
        .cfg_i   (bit_clock_pin_function_r),
        .src_i   (src_i),
        .drive_o (drive_a)
    );

    dpfm_pin_sel #(.BIT_CLOCK_VARIANT(1'b0)) u_pin_b (
        .cfg_i   (word_clock_pin_function_r),
        .src_i   (src_i),
        .drive_o (drive_b)
    );

    // ========================================================================
    // Registered pin drivers; one cycle of latency keeps outputs glitch free
    // ========================================================================
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            bit_clock_shared_pin_o    <= 1'b0;
            bit_clock_shared_pin_oe_o <= 1'b0;
            bit_clock_shared_pin_ie_o <= 1'b1;   // Reset state is input mode
        end else begin
            bit_clock_shared_pin_o    <= drive_a.out & drive_a.oe;
            bit_clock_shared_pin_oe_o <= drive_a.oe;
            bit_clock_shared_pin_ie_o <= drive_a.ie;
        end
    end

    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            word_clock_shared_pin_o    <= 1'b0;
            word_clock_shared_pin_oe_o <= 1'b0;
            word_clock_shared_pin_ie_o <= 1'b1;
        end else begin
            word_clock_shared_pin_o    <= drive_b.out & drive_b.oe;
            word_clock_shared_pin_oe_o <= drive_b.oe;
            word_clock_shared_pin_ie_o <= drive_b.ie;
        end
    end

    // Input level to the input mux; held low while the input buffer is off
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pin_a_input_mux_o <= 1'b0;
            pin_b_input_mux_o <= 1'b0;
        end else begin
            pin_a_input_mux_o <= bit_clock_shared_pin_i & drive_a.ie;
            pin_b_input_mux_o <= word_clock_shared_pin_i & drive_b.ie;
        end
    end

endmodule : dpfm_top

//--- testbench/dpfm_pin_model.sv
// Far-side circuit on one pin: an external level that the pin driver
// overrides while its output enable is high.
`timescale 1ns/1ps
module dpfm_pin_model (
    input  wire logic oe_i,
    input  wire logic out_i,
    input  wire logic ext_i,
    output logic      pin_o
);
    // Resolved wire level fed back to the pin's input buffer
    assign pin_o = oe_i ? out_i : ext_i;
endmodule : dpfm_pin_model

//--- testbench/dpfm_monitor.sv
// Checker for the dual pin function mux, bound to its top module.
// Assumes pins show a register value one edge after it is stored.
`timescale 1ns/1ps
module dpfm_monitor
    import dpfm_pkg::*;
(
    input wire logic       core_clk_i,
    input wire logic       resetn_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic       reg_wr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic [7:0] reg_rdata_o,
    input wire dpfm_src_t  src_i,
    input wire logic       bit_clock_shared_pin_o,
    input wire logic       bit_clock_shared_pin_oe_o,
    input wire logic       bit_clock_shared_pin_ie_o,
    input wire logic       word_clock_shared_pin_o,
    input wire logic       word_clock_shared_pin_oe_o,
    input wire logic       word_clock_shared_pin_ie_o
);
    // ========================================================================
    // Shadow registers, so pin checks need no view of the internals
    // ========================================================================
    logic [7:0] cfg_a_r;
    logic [7:0] cfg_b_r;
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cfg_a_r <= DPFM_PIN_FUNCTION_RESET;
            cfg_b_r <= DPFM_PIN_FUNCTION_RESET;
        end else if (reg_wr_i) begin
            if (reg_addr_i == DPFM_BIT_CLOCK_PIN_FUNCTION_OFS) cfg_a_r <= reg_wdata_i;
            if (reg_addr_i == DPFM_WORD_CLOCK_PIN_FUNCTION_OFS) cfg_b_r <= reg_wdata_i;
        end
    end
    // ========================================================================
    // Assertions; $past(resetn_i) skips the edge that leaves reset
    // ========================================================================
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!resetn_i);
    chk_read_back: assert property ($past(resetn_i) &&
        $past(reg_addr_i) == DPFM_WORD_CLOCK_PIN_FUNCTION_OFS |-> reg_rdata_o == $past(cfg_b_r))
        else $error("read data differs from register");
    chk_level_drive: assert property ($past(resetn_i) && $past(cfg_b_r[4:0]) == 5'h03
        |-> word_clock_shared_pin_oe_o && word_clock_shared_pin_o == $past(cfg_b_r[6]))
        else $error("pin b level drive wrong");
    chk_bitbang_drive: assert property ($past(resetn_i) && $past(cfg_a_r[4:0]) == 5'h04
        |-> bit_clock_shared_pin_oe_o
            && bit_clock_shared_pin_o == $past(src_i.shared_bitbang_level))
        else $error("pin a bit-bang drive wrong");
    chk_input_mode: assert property ($past(resetn_i) && $past(cfg_a_r[4:0]) == 5'h01
        |-> !bit_clock_shared_pin_oe_o && bit_clock_shared_pin_ie_o)
        else $error("pin a input mode wrong");
    chk_disabled_off: assert property ($past(resetn_i) && $past(cfg_b_r[4:0]) == 5'h00
        |-> !word_clock_shared_pin_oe_o && !word_clock_shared_pin_ie_o)
        else $error("pin b not powered down");
    chk_pdm_clock: assert property ($past(resetn_i) &&
        $past(cfg_a_r[4:0]) inside {5'h05, 5'h06}
        |-> bit_clock_shared_pin_oe_o && bit_clock_shared_pin_o == $past(src_i.pdm_clock))
        else $error("pin a pdm clock wrong");
    chk_clock_out: assert property ($past(resetn_i) && $past(cfg_b_r[4:0]) == 5'h06
        |-> word_clock_shared_pin_oe_o
            && word_clock_shared_pin_o == $past(src_i.general_clock_output))
        else $error("pin b clock output wrong");
    chk_reserved_off: assert property ($past(resetn_i) &&
        $past(cfg_b_r[4:0]) inside {5'h02, 5'h0B, 5'h0E, 5'h0F, 5'h13, 5'h14,
                                    [5'h16:5'h1A], 5'h1E, 5'h1F}
        |-> !word_clock_shared_pin_oe_o && !word_clock_shared_pin_o)
        else $error("pin b driven on reserved code");
endmodule : dpfm_monitor
bind dpfm_top dpfm_monitor u_dpfm_monitor (.core_clk_i(core_clk_i), .resetn_i(resetn_i),
    .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i),
    .reg_rdata_o(reg_rdata_o), .src_i(src_i), .bit_clock_shared_pin_o(bit_clock_shared_pin_o),
    .bit_clock_shared_pin_oe_o(bit_clock_shared_pin_oe_o),
    .bit_clock_shared_pin_ie_o(bit_clock_shared_pin_ie_o),
    .word_clock_shared_pin_o(word_clock_shared_pin_o),
    .word_clock_shared_pin_oe_o(word_clock_shared_pin_oe_o),
    .word_clock_shared_pin_ie_o(word_clock_shared_pin_ie_o));

//--- testbench/tb.sv
// Bench for the dual pin function mux: reset values, unmapped access,
// every selector code on both pins, and a reset in mid-run.
// Assumes inputs change at the falling edge of the 10 MHz clock.
`timescale 1ns/1ps
module tb
    import dpfm_pkg::*;
;
    logic       clk = 1'b0;
    logic       rst_n = 1'b0;
    logic [7:0] addr = 8'h00;
    logic       wr = 1'b0;
    logic [7:0] wdata = 8'h00;
    logic [7:0] rdata;
    dpfm_src_t  src = '0;
    logic [1:0] ext = 2'b00;
    logic [1:0] pin_in, pin_o, pin_oe, pin_ie, mux;
    int         fail_count = 0;
    int         checked = 0;
    always #50 clk = ~clk;
    // Far-side circuits: index 0 is pin A, index 1 is pin B
    dpfm_pin_model u_pa (.oe_i(pin_oe[0]), .out_i(pin_o[0]), .ext_i(ext[0]), .pin_o(pin_in[0]));
    dpfm_pin_model u_pb (.oe_i(pin_oe[1]), .out_i(pin_o[1]), .ext_i(ext[1]), .pin_o(pin_in[1]));
    dpfm_top dut (.core_clk_i(clk), .resetn_i(rst_n), .reg_addr_i(addr), .reg_wr_i(wr),
        .reg_wdata_i(wdata), .reg_rdata_o(rdata), .src_i(src),
        .bit_clock_shared_pin_i(pin_in[0]), .bit_clock_shared_pin_o(pin_o[0]),
        .bit_clock_shared_pin_oe_o(pin_oe[0]), .bit_clock_shared_pin_ie_o(pin_ie[0]),
        .pin_a_input_mux_o(mux[0]), .word_clock_shared_pin_i(pin_in[1]),
        .word_clock_shared_pin_o(pin_o[1]), .word_clock_shared_pin_oe_o(pin_oe[1]),
        .word_clock_shared_pin_ie_o(pin_ie[1]), .pin_b_input_mux_o(mux[1]));
    // ========================================================================
    // Access and compare tasks
    // ========================================================================
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        addr = a;
        wdata = d;
        wr = 1'b1;
        @(negedge clk);
        wr = 1'b0;
    endtask : wr_reg
    // Read data is registered, so it is looked at one edge later
    task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp, input string what);
        @(negedge clk);
        addr = a;
        @(negedge clk);
        check(what, exp, rdata);
    endtask : rd_reg
    // Source bit per code; 15 means the pin's own level bit, -1 no drive
    function automatic int src_idx(input logic [4:0] c, input bit pa);
        case (c)
            5'h03: return 15;
            5'h04: return 14;
            5'h05: return 13;
            5'h06: return pa ? 13 : 12;
            5'h07: return 11;
            5'h08: return 10;
            5'h09: return pa ? 10 : 9;
            5'h0A: return pa ? 9 : 8;
            5'h0C, 5'h11: return 7;
            5'h0D: return 6;
            5'h10: return 5;
            5'h12: return 4;
            5'h15: return 3;
            5'h1B: return 2;
            5'h1C: return 1;
            5'h1D: return 0;
            default: return -1;
        endcase
    endfunction : src_idx
    // Every code twice, with opposite source patterns and level bits
    task automatic sweep(input int p);
        int         ix;
        logic [7:0] cfg;
        logic [7:0] e;
        logic [7:0] g;
        logic [7:0] ofs;
        ofs = p ? DPFM_WORD_CLOCK_PIN_FUNCTION_OFS : DPFM_BIT_CLOCK_PIN_FUNCTION_OFS;
        for (int c = 0; c < 32; c++) begin
            for (int k = 0; k < 2; k++) begin
                ix = src_idx(c[4:0], p == 0);
                cfg = c[7:0] | (k ? 8'h40 : 8'hA0);
                @(negedge clk);
                src = k ? 15'h2AAA : 15'h5555;
                ext = k ? 2'b00 : 2'b11;
                wr_reg(ofs, cfg);
                @(negedge clk);
                e = {4'h0, ix >= 0, c == 1, ix == 15 ? k[0] : ix >= 0 ? src[ix] : 1'b0,
                     c == 1 ? ext[p] : 1'b0};
                g = {4'h0, pin_oe[p], pin_ie[p], pin_o[p], mux[p]};
                check("pin drive", e, g);
                rd_reg(ofs, cfg, "register read back");
            end
        end
        $display("test sweep of pin %0d done", p);
    endtask : sweep
    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : end_of_test
    // ========================================================================
    // Main sequence and watchdog
    // ========================================================================
    initial begin
        repeat (4) @(negedge clk);
        rst_n = 1'b1;
        rd_reg(DPFM_BIT_CLOCK_PIN_FUNCTION_OFS, 8'h01, "pin a reset value");
        check("pins after reset", {6'b001100, ext}, {pin_oe, pin_ie, pin_o, mux});
        wr_reg(8'h3F, 8'hFF);
        rd_reg(8'h3F, 8'h00, "unmapped read");
        rd_reg(DPFM_BIT_CLOCK_PIN_FUNCTION_OFS, 8'h01, "pin a after stray write");
        rd_reg(DPFM_WORD_CLOCK_PIN_FUNCTION_OFS, 8'h01, "pin b after stray write");
        $display("test reset and map done");
        sweep(0);
        sweep(1);
        wr_reg(DPFM_WORD_CLOCK_PIN_FUNCTION_OFS, 8'h43);
        rst_n = 1'b0;
        @(negedge clk);
        rst_n = 1'b1;
        rd_reg(DPFM_WORD_CLOCK_PIN_FUNCTION_OFS, 8'h01, "pin b after second reset");
        check("pin b drive after second reset", {7'h02, ext[1]},
              {4'h0, pin_oe[1], pin_ie[1], pin_o[1], mux[1]});
        $display("test second reset done");
        end_of_test();
    end
    // About 800 cycles are needed; the limit leaves nearly four times that
    initial begin
        #(100 * 3000);
        fail_count++;
        end_of_test();
    end
endmodule : tb
